// >>> core/cit_pkg.sv
// Package for the card interface timer: register map, fields, types
package cit_pkg;

  localparam int unsigned CIT_ADDR_W = 12;
  localparam int unsigned CIT_CNT_W = 24;
  localparam int unsigned CIT_MODE_W = 4;

  localparam logic [CIT_ADDR_W-1:0] CIT_CTRL_OFF = 12'h028;
  localparam logic [CIT_ADDR_W-1:0] CIT_STAT_OFF = 12'h02c;

  // Control register field layout
  localparam int unsigned CIT_CNT_LSB = 0;
  localparam int unsigned CIT_CNT_MSB = 23;
  localparam int unsigned CIT_MODE_LSB = 24;
  localparam int unsigned CIT_MODE_MSB = 27;

  // Status register field layout
  localparam int unsigned CIT_STAT_COUNTING_BIT = 24;
  localparam int unsigned CIT_STAT_ARMED_BIT = 25;

  localparam logic [31:0] CIT_CTRL_RESET = 32'h0000_0000;
  localparam logic [CIT_CNT_W-1:0] CIT_CNT_ZERO = 24'h00_0000;
  localparam logic [CIT_CNT_W-1:0] CIT_CNT_ONE = 24'h00_0001;

  // Operation modes
  localparam logic [CIT_MODE_W-1:0] CIT_MODE_ONESHOT_EN = 4'h0;
  localparam logic [CIT_MODE_W-1:0] CIT_MODE_ONESHOT_ANY = 4'h1;
  localparam logic [CIT_MODE_W-1:0] CIT_MODE_ONESHOT_RX = 4'h2;
  localparam logic [CIT_MODE_W-1:0] CIT_MODE_ANSWER_WAIT = 4'h3;
  localparam logic [CIT_MODE_W-1:0] CIT_MODE_RELOAD_EN = 4'h4;
  localparam logic [CIT_MODE_W-1:0] CIT_MODE_RELOAD_ANY = 4'h5;
  localparam logic [CIT_MODE_W-1:0] CIT_MODE_RELOAD_RX = 4'h6;

  typedef struct packed {
    logic [CIT_MODE_W-1:0] timer_op_select;
    logic [CIT_CNT_W-1:0] reload_count;
  } cit_ctrl_s;

  typedef struct packed {
    logic rx_start;
    logic tx_start;
    logic answer_received;
  } cit_evt_s;

  typedef enum logic [1:0] {
    CIT_IDLE,
    CIT_ARMED,
    CIT_COUNT,
    CIT_DONE
  } cit_state_e;

endpackage

// >>> core/cit_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module cit_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic async_in,
  output logic sync_out
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= async_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Level only moves once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_out <= 1'b0;
    end else if (s2_r == s3_r) begin
      sync_out <= s3_r;
    end
  end
endmodule // cit_sync
`default_nettype wire

// >>> core/cit_timer0.sv
// Card interface timer 0: 24-bit down counter with APB control register
//
// Notes on behaviour
// - 24-bit down counter, four-bit mode field
// - Timeout equals reload count plus one
// - Mode 0 counts once run-enable set
// - Modes 0-2 zero: flag, clear run-enable
// - Mode 1 starts on rx or tx start
// - Mode 2 starts on received start only
// - Mode 3 only for activation, warm reset
// - Mode 3 counts from reset deassert
// - Mode 3 expiry: flag, clear run-enable
// - Mode 3 answer first: clear, no flag
// - Mode 4 zero: flag, reload, keep counting
// - Live reload takes new count at zero
// - Mode 5 zero: flag, reload, await start
// - Mode 6 zero: flag, reload, await rx start
// - Start-bit reload modes re-arm until run-enable cleared
// - Control register resets to all zeros
`timescale 1ns/100ps
`default_nettype none
module cit_timer0
  import cit_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [CIT_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timer_run_enable,
  input wire logic live_reload_enable,
  input wire logic count_tick,
  input wire logic rx_start_bit,
  input wire logic tx_start_bit,
  input wire logic answer_received,
  input wire logic card_reset_line,
  output logic timer_expired_flag,
  output logic timer_run_clear,
  output logic timer_counting
);

  cit_ctrl_s ctrl_r;
  cit_state_e state_r;
  logic [CIT_CNT_W-1:0] cnt_r;
  logic [CIT_CNT_W-1:0] shadow_r;
  logic [31:0] prdata_r;
  logic rst_lvl;
  logic rst_lvl_d_r;
  logic rst_release;
  logic setup_ph;
  logic access_ph;
  logic addr_ok;
  logic wr_ctrl;
  logic trigger;
  logic at_zero;
  logic expire;
  logic answer_end;
  logic oneshot_mode;
  logic [CIT_CNT_W-1:0] reload_val;
  cit_evt_s evt;

  // Card reset line arrives from the pin side
  cit_sync u_rst_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(card_reset_line),
    .sync_out(rst_lvl)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_lvl_d_r <= 1'b0;
    end else begin
      rst_lvl_d_r <= rst_lvl;
    end
  end

  assign rst_release = rst_lvl & ~rst_lvl_d_r;
  assign evt = '{rx_start: rx_start_bit, tx_start: tx_start_bit,
                 answer_received: answer_received};

  // APB: zero wait states, read data captured in setup phase
  assign setup_ph = psel & ~penable;
  assign access_ph = psel & penable;
  assign addr_ok = (paddr == CIT_CTRL_OFF) || (paddr == CIT_STAT_OFF);
  assign pready = 1'b1;
  assign pslverr = access_ph & ~addr_ok;
  assign prdata = prdata_r;
  assign wr_ctrl = access_ph & pwrite & (paddr == CIT_CTRL_OFF);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= CIT_CTRL_RESET[CIT_MODE_MSB:CIT_CNT_LSB];
    end else if (wr_ctrl) begin
      // Reserved bits are never stored
      ctrl_r <= pwdata[CIT_MODE_MSB:CIT_CNT_LSB];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= CIT_CTRL_RESET;
    end else if (setup_ph && !pwrite) begin
      prdata_r <= CIT_CTRL_RESET;
      if (paddr == CIT_CTRL_OFF) begin
        prdata_r[CIT_MODE_MSB:CIT_CNT_LSB] <= ctrl_r;
      end else if (paddr == CIT_STAT_OFF) begin
        prdata_r[CIT_CNT_MSB:CIT_CNT_LSB] <= cnt_r;
        prdata_r[CIT_STAT_COUNTING_BIT] <= (state_r == CIT_COUNT);
        prdata_r[CIT_STAT_ARMED_BIT] <= (state_r == CIT_ARMED);
      end
    end
  end

  // Start condition while armed, per mode
  always_comb begin
    trigger = 1'b0;
    case (ctrl_r.timer_op_select)
      CIT_MODE_ONESHOT_ANY, CIT_MODE_RELOAD_ANY: begin
        trigger = evt.rx_start | evt.tx_start;
      end
      CIT_MODE_ONESHOT_RX, CIT_MODE_RELOAD_RX: begin
        trigger = evt.rx_start;
      end
      CIT_MODE_ANSWER_WAIT: begin
        trigger = rst_release;
      end
      default: begin
        trigger = 1'b0;
      end
    endcase
  end

  assign oneshot_mode = (ctrl_r.timer_op_select == CIT_MODE_ONESHOT_EN) ||
                        (ctrl_r.timer_op_select == CIT_MODE_ONESHOT_ANY) ||
                        (ctrl_r.timer_op_select == CIT_MODE_ONESHOT_RX) ||
                        (ctrl_r.timer_op_select == CIT_MODE_ANSWER_WAIT);
  assign at_zero = (cnt_r == CIT_CNT_ZERO);
  // Zero state lasts one tick, giving reload count plus one ticks
  assign expire = (state_r == CIT_COUNT) & count_tick & at_zero;
  // Expiry wins when the answer lands on the very expiring tick
  assign answer_end = (state_r == CIT_COUNT) & evt.answer_received & ~expire &
                      (ctrl_r.timer_op_select == CIT_MODE_ANSWER_WAIT);
  // Without live reload, the count latched at start is reused
  assign reload_val = live_reload_enable ? ctrl_r.reload_count : shadow_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= CIT_IDLE;
    end else if (!timer_run_enable) begin
      state_r <= CIT_IDLE;
    end else begin
      case (state_r)
        CIT_IDLE: begin
          case (ctrl_r.timer_op_select)
            CIT_MODE_ONESHOT_EN, CIT_MODE_RELOAD_EN: begin
              state_r <= CIT_COUNT;
            end
            CIT_MODE_ONESHOT_ANY, CIT_MODE_ONESHOT_RX, CIT_MODE_ANSWER_WAIT,
            CIT_MODE_RELOAD_ANY, CIT_MODE_RELOAD_RX: begin
              state_r <= CIT_ARMED;
            end
            default: begin
              state_r <= CIT_IDLE;
            end
          endcase
        end
        CIT_ARMED: begin
          if (trigger) begin
            state_r <= CIT_COUNT;
          end
        end
        CIT_COUNT: begin
          if (answer_end) begin
            state_r <= CIT_DONE;
          end else if (expire) begin
            if (oneshot_mode) begin
              state_r <= CIT_DONE;
            end else if (ctrl_r.timer_op_select == CIT_MODE_RELOAD_EN) begin
              state_r <= CIT_COUNT;
            end else if (ctrl_r.timer_op_select == CIT_MODE_RELOAD_RX) begin
              state_r <= CIT_ARMED;
            end else begin
              state_r <= CIT_ARMED;
            end
          end
        end
        CIT_DONE: begin
          // Hold until the enable really drops, so no restart
          state_r <= CIT_DONE;
        end
        default: begin
          state_r <= CIT_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= CIT_CNT_ZERO;
      shadow_r <= CIT_CNT_ZERO;
    end else if (timer_run_enable && state_r == CIT_IDLE) begin
      cnt_r <= ctrl_r.reload_count;
      shadow_r <= ctrl_r.reload_count;
    end else if (expire) begin
      cnt_r <= reload_val;
    end else if (state_r == CIT_COUNT && count_tick) begin
      cnt_r <= cnt_r - CIT_CNT_ONE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_expired_flag <= 1'b0;
      timer_run_clear <= 1'b0;
    end else begin
      timer_expired_flag <= expire;
      timer_run_clear <= answer_end | (expire & oneshot_mode);
    end
  end

  assign timer_counting = (state_r == CIT_COUNT);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_expire_oneshot;
    expire && oneshot_mode;
  endsequence

  property p_reserved_zero;
    access_ph && !pwrite |-> prdata[31:28] == 4'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bits read nonzero");

  property p_flag_cause;
    timer_expired_flag |-> $past(state_r == CIT_COUNT && count_tick && at_zero);
  endproperty
  a_flag_cause: assert property (p_flag_cause)
    else $error("flag without zero tick");

  property p_oneshot_stop;
    s_expire_oneshot |=> timer_run_clear && timer_expired_flag &&
                         (!timer_run_enable || state_r == CIT_DONE);
  endproperty
  a_oneshot_stop: assert property (p_oneshot_stop)
    else $error("one-shot expiry did not stop");

  property p_mode0_start;
    state_r == CIT_IDLE && timer_run_enable &&
      ctrl_r.timer_op_select == CIT_MODE_ONESHOT_EN
      |=> state_r == CIT_COUNT && cnt_r == $past(ctrl_r.reload_count);
  endproperty
  a_mode0_start: assert property (p_mode0_start)
    else $error("mode 0 did not start counting");

  property p_rx_only;
    state_r == CIT_ARMED && timer_run_enable && !rx_start_bit &&
      ctrl_r.timer_op_select == CIT_MODE_ONESHOT_RX |=> state_r != CIT_COUNT;
  endproperty
  a_rx_only: assert property (p_rx_only)
    else $error("started without received start bit");

  property p_reload_run;
    expire && timer_run_enable && ctrl_r.timer_op_select == CIT_MODE_RELOAD_EN
      |=> state_r == CIT_COUNT && cnt_r == $past(reload_val) && !timer_run_clear;
  endproperty
  a_reload_run: assert property (p_reload_run)
    else $error("mode 4 did not reload");

  property p_rearm;
    expire && timer_run_enable && ctrl_r.timer_op_select == CIT_MODE_RELOAD_ANY
      |=> state_r == CIT_ARMED ##1 (state_r == CIT_ARMED || trigger ||
                                    !timer_run_enable || $past(trigger));
  endproperty
  a_rearm: assert property (p_rearm)
    else $error("mode 5 did not re-arm");

  property p_answer_end;
    answer_end |=> timer_run_clear && !timer_expired_flag;
  endproperty
  a_answer_end: assert property (p_answer_end)
    else $error("answer did not end without flag");

  property p_undef_idle;
    ctrl_r.timer_op_select > CIT_MODE_RELOAD_RX && state_r == CIT_IDLE
      |=> state_r == CIT_IDLE;
  endproperty
  a_undef_idle: assert property (p_undef_idle)
    else $error("undefined mode left idle");

  property p_reset_start;
    state_r == CIT_ARMED && timer_run_enable && rst_release &&
      ctrl_r.timer_op_select == CIT_MODE_ANSWER_WAIT |=> timer_counting;
  endproperty
  a_reset_start: assert property (p_reset_start)
    else $error("reset release did not start count");

endmodule // cit_timer0
`default_nettype wire

// >>> verification/cit_card_model.sv
// Card-side event source: start bits, answer to reset, card reset line
`timescale 1ns/100ps
`default_nettype none
module cit_card_model (
  input wire logic pclk,
  output logic rx_start_bit,
  output logic tx_start_bit,
  output logic answer_received,
  output logic card_reset_line
);
  initial begin
    rx_start_bit = 1'b0;
    tx_start_bit = 1'b0;
    answer_received = 1'b0;
    card_reset_line = 1'b0;
  end

  // One-cycle event: 0 receive start, 1 transmit start, 2 answer
  task automatic pulse(input int which);
    @(posedge pclk);
    case (which)
      0: rx_start_bit <= 1'b1;
      1: tx_start_bit <= 1'b1;
      default: answer_received <= 1'b1;
    endcase
    @(posedge pclk);
    rx_start_bit <= 1'b0;
    tx_start_bit <= 1'b0;
    answer_received <= 1'b0;
  endtask

  // Level of the reset line; high means released
  task automatic set_reset_line(input logic lvl);
    @(posedge pclk);
    card_reset_line <= lvl;
  endtask
endmodule // cit_card_model
`default_nettype wire

// >>> verification/test_card_interface_timer0.sv
// Self-checking bench for card interface timer 0
`timescale 1ns/100ps
`default_nettype none
module test_card_interface_timer0;
  import cit_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, run_en, live, tick, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic rx, tx, ans, rst_line, flag, clr, counting, e, f, c;
  logic [23:0] n;
  logic [3:0] m;
  int n_mismatch, num_checks, i, seed;

  cit_timer0 DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_run_enable(run_en), .live_reload_enable(live),
    .count_tick(tick), .rx_start_bit(rx), .tx_start_bit(tx), .answer_received(ans),
    .card_reset_line(rst_line), .timer_expired_flag(flag), .timer_run_clear(clr),
    .timer_counting(counting));
  cit_card_model card (.pclk(pclk), .rx_start_bit(rx), .tx_start_bit(tx),
    .answer_received(ans), .card_reset_line(rst_line));

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      n_mismatch++;
      tally_and_finish();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_cnt(input logic v);
    for (int k = 0; k < 14 && counting !== v; k++) @(negedge pclk);
    chk(32'(counting), 32'(v));
    if (counting !== v) tally_and_finish();
  endtask

  // Three cycles of watching for the expiry and run-clear pulses
  task automatic watch;
    repeat (3) begin
      @(negedge pclk);
      f = f | (flag === 1'b1);
      c = c | (clr === 1'b1);
    end
  endtask

  // Random ticks while nothing may count, then quiet again
  task automatic idle_ticks(input int cyc);
    repeat (cyc) begin
      @(posedge pclk);
      tick <= 1'($urandom);
    end
    @(posedge pclk);
    tick <= 1'b0;
    @(negedge pclk);
  endtask

  // Ticks one at a time until expiry; the tick count must match
  task automatic period(input int exp_ticks, input logic exp_clr);
    int k;
    f = 1'b0;
    c = 1'b0;
    for (k = 0; k < exp_ticks + 2 && !f; k++) begin
      @(posedge pclk);
      tick <= 1'b1;
      @(posedge pclk);
      tick <= 1'b0;
      watch();
    end
    chk(32'(k), 32'(exp_ticks));
    chk(32'(c), 32'(exp_clr));
  endtask

  task automatic start(input logic [3:0] md, input logic [23:0] cnt);
    apb(1'b1, CIT_CTRL_OFF, {4'h0, md, cnt});
    @(posedge pclk);
    run_en <= 1'b1;
  endtask

  task automatic stop;
    @(posedge pclk);
    run_en <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask

  initial begin
    {presetn, psel, penable, pwrite, run_en, live, tick} = 7'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    n_mismatch = 0;
    num_checks = 0;
    seed = $urandom(31);
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, CIT_CTRL_OFF, 32'h0);
    chk(q, CIT_CTRL_RESET);
    apb(1'b1, CIT_CTRL_OFF, 32'hffff_ffff);
    apb(1'b0, CIT_CTRL_OFF, 32'h0);
    chk(q, 32'h0fff_ffff);
    apb(1'b0, 12'h030, 32'h0);
    chk(32'(e), 32'h1);
    // One-shot modes with random counts, then a zero count
    for (i = 0; i < 4; i++) begin
      m = (i == 3) ? 4'h0 : 4'(i);
      n = (i == 3) ? 24'h0 : 24'($urandom % 6 + 1);
      live <= 1'($urandom);
      start(m, n);
      if (m == 4'h2) begin
        card.pulse(1);
        idle_ticks(6);
        chk(32'(counting), 32'h0);
        apb(1'b0, CIT_STAT_OFF, 32'h0);
        chk(q, 32'(n) | (32'h1 << CIT_STAT_ARMED_BIT));
      end
      if (m != 4'h0) card.pulse(m == 4'h1 ? 1 : 0);
      wait_cnt(1'b1);
      period(int'(n) + 1, 1'b1);
      stop();
    end
    // Answer wait: answer first, then expiry
    for (i = 0; i < 2; i++) begin
      card.set_reset_line(1'b0);
      start(CIT_MODE_ANSWER_WAIT, 24'h4);
      idle_ticks(6);
      chk(32'(counting), 32'h0);
      card.set_reset_line(1'b1);
      wait_cnt(1'b1);
      if (i == 0) begin
        f = 1'b0;
        c = 1'b0;
        card.pulse(2);
        watch();
        chk({30'h0, f, c}, 32'h1);
      end else period(5, 1'b1);
      stop();
    end
    // Free-running reload with a live rewrite of the count
    live <= 1'b1;
    start(CIT_MODE_RELOAD_EN, 24'h3);
    wait_cnt(1'b1);
    period(4, 1'b0);
    apb(1'b0, CIT_STAT_OFF, 32'h0);
    chk(q, 32'h3 | (32'h1 << CIT_STAT_COUNTING_BIT));
    apb(1'b1, CIT_CTRL_OFF, {8'h04, 24'h5});
    period(4, 1'b0);
    period(6, 1'b0);
    chk(32'(counting), 32'h1);
    stop();
    live <= 1'b0;
    // Start-bit reload modes re-arm after each expiry
    for (i = 5; i < 7; i++) begin
      start(4'(i), 24'h2);
      card.pulse(i == 5 ? 1 : 0);
      wait_cnt(1'b1);
      period(3, 1'b0);
      wait_cnt(1'b0);
      if (i == 6) begin
        card.pulse(1);
        idle_ticks(4);
        chk(32'(counting), 32'h0);
      end
      card.pulse(0);
      wait_cnt(1'b1);
      period(3, 1'b0);
      stop();
    end
    // Undefined mode stays idle
    start(4'h9, 24'h1);
    card.pulse(0);
    idle_ticks(6);
    chk(32'(counting), 32'h0);
    stop();
    tally_and_finish();
  end
endmodule // test_card_interface_timer0
`default_nettype wire
